// ### design/buvm_pkg.sv
// Purpose: shared constants and types for the boost undervoltage monitor and ground-loss shut-off
// Assumes: 200 MHz core clock, 16-bit registers at 9-bit word addresses
// Notes: field positions inside the two registers are fixed here and nowhere else, except the dac code bits 15:8 that an assertion in the top spells out
package buvm_pkg;
    // register addresses
    localparam logic [8:0] ADDR_FAULT_CONFIG = 9'h1c5;
    localparam logic [8:0] ADDR_FAULT_STATE = 9'h1d2;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    // config field positions
    localparam int CFG_IRQ_EN_BIT = 0;
    localparam int CFG_UV_MODE_BIT = 1;
    localparam int CFG_SHUTOFF_EN_BIT = 2;
    localparam int CFG_DAC_LSB = 8;
    // status field positions
    localparam int ST_BOOST_UV_BIT = 0;
    localparam int ST_PSU_UV_BIT = 1;
    localparam int ST_FIVE_UV_BIT = 2;
    localparam int ST_GND_LOST_BIT = 3;
    // pre-driver counts
    localparam int HS_NUM = 5;
    localparam int LS_NUM = 7;
    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int GND_FLT_NS = 1300000;
    localparam int GND_FLT_CYCLES = (GND_FLT_NS * 1000) / CLK_PERIOD_PS;
    localparam int GND_CNT_W = 19;
    localparam logic [2:0] BOOST_FLT_CYCLES = 3'h4;
    // ground filter states
    typedef enum logic [2:0] {
        GS_IDLE = 3'b001,
        GS_COUNT = 3'b010,
        GS_TRIP = 3'b100
    } buvm_gnd_state_type;
    // decoded configuration fields
    typedef struct packed {
        logic [7:0] dac_code;
        logic shutoff_en;
        logic uv_mode;
        logic irq_en;
    } buvm_cfg_type;
    // synchronised analog indications
    typedef struct packed {
        logic [2:0] gnd_lost;
        logic five_uv;
        logic psu_uv;
        logic boost_fbk;
    } buvm_ana_type;
    // unpack the config register, used by decode; the output path reads the register bits directly
    function automatic buvm_cfg_type buvm_cfg_decode(input logic [15:0] r);
        buvm_cfg_type c;
        c.dac_code = r[CFG_DAC_LSB +: 8];
        c.shutoff_en = r[CFG_SHUTOFF_EN_BIT];
        c.uv_mode = r[CFG_UV_MODE_BIT];
        c.irq_en = r[CFG_IRQ_EN_BIT];
        return c;
    endfunction
endpackage

// ### design/buvm_sync.sv
// Purpose: three-stage synchroniser with agreement qualifier for analog indications
// Assumes: inputs are asynchronous levels
// Notes: the first stage feeds only the second, so metastability never reaches a compare
`timescale 1ns/10ps
module buvm_sync
    import buvm_pkg::*;
#(
    parameter int W = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] level_o
);
    logic [W-1:0] s1_ff; // first stage, read by s2 only
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] lvl_ff; // qualified level
    logic [W-1:0] nxt_lvl;

    // per bit: accept a change once stage two and three agree
    genvar g;
    for (g = 0; g < W; g++) begin : g_bit
        always_comb begin
            nxt_lvl[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : lvl_ff[g];
        end
    end

    // stage registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            lvl_ff <= '0;
        end else if (ce_i) begin
            s1_ff <= async_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    assign level_o = lvl_ff;
endmodule // buvm_sync

// ### design/buvm_top.sv
// Purpose: digital side of boost undervoltage monitor and missing-ground shut-off
// Assumes: register strobes come from the serial front end on REF_CLK_I
// Notes: comparator and ground-loss lines are asynchronous and are synchronised here
// Operation
// - mode bit selects quarter divider
// - comparator result shuts high-side drivers when enabled
// - undervoltage rises when voltage below threshold
// - digital filter active in undervoltage mode
// - undervoltage ORed with supply faults, gates high-side drivers
// - undervoltage event sets status bit
// - enabled undervoltage raises interrupt request
// - detect any lost ground connection
// - ground loss asserts supply undervoltage, all off
// - ground loss filtered for fixed time
// - eight-bit unsigned code drives threshold DAC
// - comparator high above threshold, low below
`timescale 1ns/10ps
module buvm_top
    import buvm_pkg::*;
#(
    parameter int GND_FLT_CYC = GND_FLT_CYCLES
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic [8:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic BOOST_FBK_I,
    input wire logic PSU_UV_I,
    input wire logic FIVE_UV_I,
    input wire logic [2:0] GND_LOST_I,
    input wire logic [HS_NUM-1:0] HS_CMD_I,
    input wire logic [LS_NUM-1:0] LS_CMD_I,
    output logic [15:0] REG_RDATA_O,
    output logic [7:0] DAC_CODE_O,
    output logic DIV_QUARTER_O,
    output logic BOOST_UV_O,
    output logic PSU_UV_O,
    output logic IRQ_O,
    output logic [HS_NUM-1:0] HS_GATE_O,
    output logic [LS_NUM-1:0] LS_GATE_O
);
    localparam logic [GND_CNT_W-1:0] GND_LAST = GND_CNT_W'(GND_FLT_CYC - 1);

    buvm_ana_type ana; // synchronised analog lines
    buvm_cfg_type cfg; // decoded configuration
    logic [15:0] cfg_ff; // config register
    logic [15:0] nxt_cfg;
    logic [15:0] rdata_ff; // read data
    logic [15:0] nxt_rdata;
    logic bfilt_ff; // filtered comparator
    logic nxt_bfilt;
    logic [2:0] bcnt_ff; // disagreement run length
    logic [2:0] nxt_bcnt;
    logic uv_ff; // boost undervoltage
    logic nxt_uv;
    logic stat_ff; // sticky boost status
    logic nxt_stat;
    logic irq_ff;
    logic nxt_irq;
    logic psu_ff; // combined supply undervoltage
    logic nxt_psu;
    logic [HS_NUM-1:0] hs_ff;
    logic [HS_NUM-1:0] nxt_hs;
    logic [LS_NUM-1:0] ls_ff;
    logic [LS_NUM-1:0] nxt_ls;
    buvm_gnd_state_type gst_ff; // ground filter state
    buvm_gnd_state_type nxt_gst;
    logic [GND_CNT_W-1:0] gcnt_ff;
    logic [GND_CNT_W-1:0] nxt_gcnt;
    logic gnd_any; // any ground lost
    logic cfg_wr; // config write strobe
    logic st_rd; // status read strobe

    // synchronise the asynchronous analog indications
    buvm_sync #(.W(6)) u_sync (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .async_i({GND_LOST_I, FIVE_UV_I, PSU_UV_I, BOOST_FBK_I}),
        .level_o(ana)
    );

    assign cfg = buvm_cfg_decode(cfg_ff);
    assign gnd_any = |ana.gnd_lost; // one or several grounds missing
    assign cfg_wr = REG_WR_I && (REG_ADDR_I == ADDR_FAULT_CONFIG);
    assign st_rd = REG_RD_I && (REG_ADDR_I == ADDR_FAULT_STATE);

    // register write and read path
    always_comb begin
        nxt_cfg = cfg_wr ? REG_WDATA_I : cfg_ff;
        nxt_rdata = 16'h0000; // unmapped reads return zero
        if (REG_RD_I && (REG_ADDR_I == ADDR_FAULT_CONFIG)) begin
            nxt_rdata = cfg_ff;
        end else if (st_rd) begin
            nxt_rdata[ST_BOOST_UV_BIT] = stat_ff;
            nxt_rdata[ST_PSU_UV_BIT] = psu_ff;
            nxt_rdata[ST_FIVE_UV_BIT] = ana.five_uv;
            nxt_rdata[ST_GND_LOST_BIT] = gnd_any;
        end
    end

    // comparator filter: bypassed in monitor mode, debounced in undervoltage mode
    always_comb begin
        nxt_bcnt = 3'h0;
        nxt_bfilt = bfilt_ff;
        if (!cfg.uv_mode) begin
            nxt_bfilt = ana.boost_fbk; // high above threshold, low below
        end else if (ana.boost_fbk != bfilt_ff) begin
            // change accepted only after a run of agreeing samples
            if (bcnt_ff == BOOST_FLT_CYCLES - 3'h1) begin
                nxt_bfilt = ana.boost_fbk;
            end else begin
                nxt_bcnt = bcnt_ff + 3'h1;
            end
        end
    end

    // undervoltage, sticky status and interrupt
    always_comb begin
        nxt_uv = cfg.shutoff_en && !nxt_bfilt; // below threshold, shut-off enabled
        // set wins over the clearing read so no event is lost
        nxt_stat = nxt_uv || (stat_ff && !st_rd);
        nxt_irq = cfg.irq_en && nxt_stat; // request held until status is read
    end

    // missing-ground filter state machine
    always_comb begin
        nxt_gst = gst_ff;
        nxt_gcnt = gcnt_ff;
        case (gst_ff)
            GS_IDLE: begin
                nxt_gcnt = '0;
                if (gnd_any) begin
                    nxt_gst = GS_COUNT;
                end
            end
            GS_COUNT: begin
                if (!gnd_any) begin
                    nxt_gst = GS_IDLE; // glitch shorter than filter time
                end else if (gcnt_ff == GND_LAST) begin
                    nxt_gst = GS_TRIP; // filter time elapsed
                end else begin
                    nxt_gcnt = gcnt_ff + 1'b1;
                end
            end
            GS_TRIP: begin
                if (!gnd_any) begin
                    nxt_gst = GS_IDLE;
                end
            end
            default: begin
                nxt_gst = GS_IDLE;
            end
        endcase
    end

    // driver gating; computed from next values so gates drop with the flag
    always_comb begin
        nxt_psu = ana.psu_uv || (nxt_gst == GS_TRIP); // ground loss forces supply undervoltage
        nxt_hs = HS_CMD_I & {HS_NUM{!(nxt_uv || nxt_psu || ana.five_uv)}};
        nxt_ls = LS_CMD_I & {LS_NUM{!(nxt_psu || ana.five_uv)}};
    end

    // state registers; clock enable freezes everything
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cfg_ff <= CONFIG_RESET;
            rdata_ff <= 16'h0000;
            bfilt_ff <= 1'b0;
            bcnt_ff <= 3'h0;
            uv_ff <= 1'b0;
            stat_ff <= 1'b0;
            irq_ff <= 1'b0;
            psu_ff <= 1'b0;
            hs_ff <= '0;
            ls_ff <= '0;
            gst_ff <= GS_IDLE;
            gcnt_ff <= '0;
        end else if (CE_I) begin
            cfg_ff <= nxt_cfg;
            rdata_ff <= nxt_rdata;
            bfilt_ff <= nxt_bfilt;
            bcnt_ff <= nxt_bcnt;
            uv_ff <= nxt_uv;
            stat_ff <= nxt_stat;
            irq_ff <= nxt_irq;
            psu_ff <= nxt_psu;
            hs_ff <= nxt_hs;
            ls_ff <= nxt_ls;
            gst_ff <= nxt_gst;
            gcnt_ff <= nxt_gcnt;
        end
    end

    // outputs straight from flops
    assign REG_RDATA_O = rdata_ff;
    assign DAC_CODE_O = cfg_ff[CFG_DAC_LSB +: 8]; // unsigned threshold code
    assign DIV_QUARTER_O = cfg_ff[CFG_UV_MODE_BIT]; // quarter ratio in undervoltage mode
    assign BOOST_UV_O = uv_ff;
    assign PSU_UV_O = psu_ff;
    assign IRQ_O = irq_ff;
    assign HS_GATE_O = hs_ff;
    assign LS_GATE_O = ls_ff;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I || !CE_I);

    sequence s_gnd_held;
        gnd_any && gst_ff == GS_COUNT && gcnt_ff == GND_LAST;
    endsequence

    a_hs_gate_off: assert property (uv_ff || psu_ff |-> hs_ff == '0)
        else $error("high-side gate on during undervoltage");
    a_ls_gate_off: assert property (psu_ff |-> ls_ff == '0)
        else $error("low-side gate on during supply undervoltage");
    // flag is registered from the next filtered value, so compare against the filter one cycle on
    a_uv_follow: assert property (cfg.shutoff_en ##1 !bfilt_ff |-> uv_ff)
        else $error("boost undervoltage not raised");
    a_status_set: assert property ($rose(uv_ff) |-> stat_ff ##1 (stat_ff || $past(st_rd)))
        else $error("status bit not set or lost");
    // enable taken a cycle early: a write of the enable lands with the flag one cycle later
    a_irq_raise: assert property (cfg.irq_en ##1 uv_ff |-> irq_ff)
        else $error("interrupt missing on undervoltage");
    a_sticky_hold: assert property (stat_ff && !st_rd |=> stat_ff)
        else $error("status cleared without read");
    a_filter_run: assert property (cfg.uv_mode && $changed(bfilt_ff) ##0 $past(cfg.uv_mode)
        |-> $past(bcnt_ff) == BOOST_FLT_CYCLES - 3'h1)
        else $error("comparator filter accepted early");
    a_divider_sel: assert property (cfg_wr |=> DIV_QUARTER_O == $past(REG_WDATA_I[CFG_UV_MODE_BIT]))
        else $error("divider select not updated");
    a_dac_code: assert property (cfg_wr |=> DAC_CODE_O == $past(REG_WDATA_I[15:8]))
        else $error("dac code not updated");
    a_gnd_trip: assert property (s_gnd_held |=> gst_ff == GS_TRIP && psu_ff)
        else $error("ground loss not tripped after filter");
    // entry into trip only after the full count, never from a partial run
    a_gnd_early: assert property (gst_ff == GS_TRIP && $past(gst_ff) != GS_TRIP
        |-> $past(gcnt_ff) == GND_LAST)
        else $error("ground loss tripped without filtering");
endmodule // buvm_top

// ### tb/buvm_ana_model.sv
// Purpose: behavioural boost divider, threshold dac and comparator facing the core
// Assumes: boost level is given in dac steps as seen through the quarter divider
// Notes: no hysteresis; the comparator answers at once, so any latency seen is the core's own
`timescale 1ns/10ps
module buvm_ana_model
    import buvm_pkg::*;
(
    input wire logic [7:0] dac_code_i,
    input wire logic div_quarter_i,
    input wire logic [11:0] boost_q_i,
    output logic fbk_o
);
    logic [11:0] divided; // boost level after the selected divider
    // the 1/32 divider is eight times coarser than the 1/4 one
    always_comb begin
        // threshold seen at the pin is code times dac step over the divider ratio
        divided = div_quarter_i ? boost_q_i : (boost_q_i >> 3);
        fbk_o = (divided > {4'h0, dac_code_i});
    end
endmodule // buvm_ana_model

// ### tb/tb_top.sv
// Purpose: register-driven test of boost undervoltage and ground-loss shut-off
// Assumes: ground filter shortened to 20 cycles, clock enable dropped once near the end
// Notes: expectations come from the config fields and the chosen levels only
`timescale 1ns/10ps
module tb_top
    import buvm_pkg::*;
;
    logic clk, rst, ce, wr, rd, psu, five, quarter, buv, psu_uv, irq, fbk; // bench-side nets
    logic [8:0] addr; // register address
    logic [15:0] wdata, rdata, got; // bus data
    logic [2:0] gnd; // ground loss lines
    logic [HS_NUM-1:0] hs_cmd, hs_gate; // high-side path
    logic [LS_NUM-1:0] ls_cmd, ls_gate; // low-side path
    logic [7:0] dac; // threshold code
    logic [11:0] boost_q; // boost level in dac steps
    logic [2:0] pats [5] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h7}; // single, double and triple losses
    int failures, n_compared, g; // counters
    buvm_top #(.GND_FLT_CYC(20)) dut (.REF_CLK_I(clk), .RST_I(rst), .CE_I(ce), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .BOOST_FBK_I(fbk), .PSU_UV_I(psu),
        .FIVE_UV_I(five), .GND_LOST_I(gnd), .HS_CMD_I(hs_cmd), .LS_CMD_I(ls_cmd), .REG_RDATA_O(rdata),
        .DAC_CODE_O(dac), .DIV_QUARTER_O(quarter), .BOOST_UV_O(buv), .PSU_UV_O(psu_uv), .IRQ_O(irq),
        .HS_GATE_O(hs_gate), .LS_GATE_O(ls_gate));
    buvm_ana_model u_ana (.dac_code_i(dac), .div_quarter_i(quarter), .boost_q_i(boost_q), .fbk_o(fbk));
    // free-running core clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // single exit point for pass and fail
    task automatic stop_test();
        $display("errors %0d compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // word and vector compare
    task automatic chk_val(input logic [15:0] gv, input logic [15:0] ev);
        n_compared++;
        if (gv !== ev) begin
            failures++;
            $display("MISMATCH t=%0t value %h expected %h", $time, gv, ev);
        end
    endtask
    // single flag compare
    task automatic chk_bit(input logic gv, input logic ev);
        n_compared++;
        if (gv !== ev) begin
            failures++;
            $display("MISMATCH t=%0t flag %b expected %b", $time, gv, ev);
        end
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1; // step clear of the edge so callers never read outputs mid-update
    endtask
    // one-cycle read strobe, data sampled in the answer cycle
    task automatic rd_reg(input logic [8:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // let n edges pass, then step clear of them
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // bounded wait on boost or supply undervoltage
    task automatic wait_flag(input bit sel_psu, input logic ev, input int lim);
        int k;
        for (k = 0; k < lim && (sel_psu ? psu_uv : buv) !== ev; k++) tick(1);
        chk_bit(sel_psu ? psu_uv : buv, ev);
    endtask
    // boost level change on a clock edge
    task automatic set_boost(input logic [11:0] v);
        @(posedge clk);
        boost_q <= v;
        #1; // step clear of the edge
    endtask
    // hang guard, far beyond the expected run
    initial begin
        #100000;
        failures++;
        $display("MISMATCH t=%0t run did not finish", $time);
        stop_test();
    end
    // main sequence
    initial begin
        rst <= 1'b1;
        ce <= 1'b1;
        wr <= 1'b0;
        rd <= 1'b0;
        addr <= 9'h000;
        wdata <= 16'h0000;
        psu <= 1'b0;
        five <= 1'b0;
        gnd <= 3'h0;
        hs_cmd <= '0;
        ls_cmd <= '0;
        boost_q <= 12'h090;
        failures = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        rd_reg(ADDR_FAULT_CONFIG, got);
        chk_val(got, CONFIG_RESET);
        rd_reg(ADDR_FAULT_STATE, got);
        chk_val(got, 16'h0000);
        wr_reg(ADDR_FAULT_CONFIG, 16'h7c07);
        tick(2);
        chk_val(16'(dac), 16'h007c);
        chk_bit(quarter, 1'b1);
        rd_reg(ADDR_FAULT_CONFIG, got);
        chk_val(got, 16'h7c07);
        // status is read only, unmapped space reads zero
        wr_reg(ADDR_FAULT_STATE, 16'hffff);
        wr_reg(9'h1c6, 16'h1234);
        rd_reg(9'h1c6, got);
        chk_val(got, 16'h0000);
        rd_reg(ADDR_FAULT_STATE, got);
        chk_val(got, 16'h0000);
        @(posedge clk);
        hs_cmd <= '1;
        ls_cmd <= '1;
        tick(12);
        chk_val(16'(hs_gate), 16'h001f);
        // short dip must be swallowed by the filter
        set_boost(12'h070);
        set_boost(12'h070);
        set_boost(12'h090);
        tick(14);
        chk_bit(buv, 1'b0);
        // real dip below code 0x7c
        set_boost(12'h070);
        wait_flag(1'b0, 1'b1, 20);
        chk_bit(irq, 1'b1);
        chk_val(16'(hs_gate), 16'h0000);
        chk_val(16'(ls_gate), 16'h007f);
        rd_reg(ADDR_FAULT_STATE, got);
        chk_val(got & 16'h0001, 16'h0001);
        set_boost(12'h090);
        wait_flag(1'b0, 1'b0, 20);
        chk_bit(irq, 1'b1);
        rd_reg(ADDR_FAULT_STATE, got);
        chk_val(got & 16'h0001, 16'h0001);
        rd_reg(ADDR_FAULT_STATE, got);
        chk_val(got & 16'h0001, 16'h0000);
        tick(2);
        chk_bit(irq, 1'b0);
        // shut-off disabled: a dip has no effect
        wr_reg(ADDR_FAULT_CONFIG, 16'h7c03);
        set_boost(12'h070);
        tick(15);
        chk_bit(buv, 1'b0);
        chk_val(16'(hs_gate), 16'h001f);
        // shut-off on, interrupt off
        wr_reg(ADDR_FAULT_CONFIG, 16'h7c06);
        wait_flag(1'b0, 1'b1, 20);
        chk_bit(irq, 1'b0);
        set_boost(12'h090);
        wait_flag(1'b0, 1'b0, 20);
        rd_reg(ADDR_FAULT_STATE, got);
        chk_val(got & 16'h0001, 16'h0001);
        // supply undervoltages gate both sides
        @(posedge clk);
        psu <= 1'b1;
        tick(10);
        chk_val(16'(hs_gate) | 16'(ls_gate), 16'h0000);
        chk_bit(psu_uv, 1'b1);
        rd_reg(ADDR_FAULT_STATE, got);
        chk_val(got, 16'h0002);
        @(posedge clk);
        psu <= 1'b0;
        five <= 1'b1;
        tick(10);
        chk_val(16'(hs_gate), 16'h0000);
        rd_reg(ADDR_FAULT_STATE, got);
        chk_val(got, 16'h0004);
        @(posedge clk);
        five <= 1'b0;
        // each ground alone, then two and three at once
        for (g = 0; g < 5; g++) begin
            @(posedge clk);
            gnd <= pats[g];
            tick(12);
            chk_bit(psu_uv, 1'b0);
            wait_flag(1'b1, 1'b1, 40);
            chk_val(16'(hs_gate) | 16'(ls_gate), 16'h0000);
            rd_reg(ADDR_FAULT_STATE, got);
            chk_val(got, 16'h000a);
            @(posedge clk);
            gnd <= 3'h0;
            wait_flag(1'b1, 1'b0, 15);
        end
        // clock enable low: a write and a comparator dip are both held off
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(ADDR_FAULT_CONFIG, 16'h0000);
        set_boost(12'h070);
        tick(15);
        chk_val(16'(dac), 16'h007c);
        chk_bit(buv, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        wait_flag(1'b0, 1'b1, 20);
        stop_test();
    end
endmodule // tb_top
